// [cid_regs.svh]
`ifndef CID_REGS_SVH
`define CID_REGS_SVH
`define CID_PC_RST    20'h00000
`define CID_W2_TAG    4'hf
`define CID_BYTE_MAX  4'h5
`define CID_BIT_MAX   4'h9
`define CID_BIT_SKC   4'h8
`define CID_BIT_SKS   4'h9
`define CID_GRP_LIT   4'ha
`define CID_GRP_CTL   4'hb
`define CID_GRP_MOVE  4'hc
`define CID_GRP_GOTO  4'hd
`define CID_GRP_EXT   4'he
`define CID_LIT_PTR   4'hf
`define CID_CTL_RET   4'h1
`define CID_CTL_CALL  4'h2
`define CID_CTL_TBL   4'h3
`define CID_CTL_BRA   4'h4
`define CID_D_POS     9
`define CID_A_POS     8
`define CID_S_POS     0
`define CID_TW_POS    2
`define CID_PHASES    4
`endif

// [cid_pkg.sv]
`default_nettype none
package cid_pkg;
    typedef enum logic [1:0] {
        PH_Q1 = 2'h0,
        PH_Q2 = 2'h1,
        PH_Q3 = 2'h3,
        PH_Q4 = 2'h2
    } cid_phase_t;
    typedef enum logic [1:0] {
        MD_RUN   = 2'h0,
        MD_WORD2 = 2'h1,
        MD_FLUSH = 2'h3
    } cid_mode_t;
    typedef enum logic [1:0] {
        CLS_BYTE = 2'h0,
        CLS_BIT  = 2'h1,
        CLS_LIT  = 2'h2,
        CLS_CTL  = 2'h3
    } cid_class_t;
    typedef enum logic [1:0] {
        TBL_NOCHG   = 2'h0,
        TBL_POSTINC = 2'h1,
        TBL_POSTDEC = 2'h2,
        TBL_PREINC  = 2'h3
    } cid_tbl_t;
    typedef struct packed {
        logic        nop;
        logic [1:0]  cls;
        logic [5:0]  opc;
        logic [11:0] fadr;
        logic [11:0] fdst;
        logic        wfile;
        logic        wacc;
        logic        bank;
        logic [7:0]  bmask;
        logic [11:0] lit;
        logic [1:0]  psel;
        logic        pld;
        logic        ssave;
        logic        srest;
        logic [1:0]  tmode;
        logic        trd;
        logic        twr;
        logic        ext;
        logic        push;
        logic        pop;
    } cid_out_t;
    typedef struct packed {
        cid_phase_t  ph;
        cid_mode_t   md;
        logic [19:0] pc;
        logic [15:0] ir;
        logic [19:0] tgt;
        logic        tw;
        logic        chg;
        logic        skp;
        logic        adv;
        logic        exec;
        cid_out_t    o;
    } cid_state_t;
endpackage
`default_nettype wire

// [cid_decoder.sv]
// Functional notes
// - decode 75 standard plus 8 extended instructions
// - most instructions are one 16-bit word
// - four instructions span two consecutive words
// - second word carries ones in top nibble
// - lone second word executes as no-operation
// - single word one cycle, taken/jump two
// - two-word instructions take two cycles
// - instruction cycle is four clock periods
// - word splits into opcode and operand fields
// - four groups: byte, bit, literal, control
// - byte ops carry file, destination, access select
// - destination zero accumulator, one file register
// - bit ops select one bit of file
// - literal ops: constant, pointer select, none
// - control: address, shadow mode, table mode
// - access select zero access RAM, else banked
// - shadow mode one saves/restores shadow registers
// - table pointer mode: none, post inc/dec, pre-inc
`default_nettype none
`include "cid_regs.svh"
module cid_decoder
    import cid_pkg::*;
(
    input  wire logic        CORE_CLK,
    input  wire logic        RST_N,
    input  wire logic [15:0] PROG_DATA,
    input  wire logic        COND_TRUE,
    input  wire logic [19:0] RET_ADDR,
    output logic      [19:0] PROG_ADDR,
    output logic             EXEC_STB,
    output logic             IS_NOP,
    output logic      [1:0]  OP_CLASS,
    output logic      [5:0]  OPCODE,
    output logic      [11:0] FILE_ADDR,
    output logic      [11:0] FILE_DST,
    output logic             WR_FILE,
    output logic             WR_ACCUM,
    output logic             BANKED,
    output logic      [7:0]  BIT_MASK,
    output logic      [11:0] LITERAL,
    output logic      [1:0]  PTR_SEL,
    output logic             PTR_LOAD,
    output logic             SHADOW_SAVE,
    output logic             SHADOW_RESTORE,
    output logic      [1:0]  TBL_MODE,
    output logic             TBL_RD,
    output logic             TBL_WR,
    output logic             EXT_OP,
    output logic             STACK_PUSH,
    output logic             STACK_POP
);
    localparam cid_out_t NOP_OUT = '{nop: 1'b1, default: '0};
    localparam cid_state_t RST_ST = '{
        ph: PH_Q1, md: MD_RUN, pc: `CID_PC_RST, ir: 16'h0000,
        tgt: 20'h00000, tw: 1'b0, chg: 1'b0, skp: 1'b0,
        adv: 1'b0, exec: 1'b0, o: NOP_OUT};

    cid_state_t  s;
    cid_state_t  next_s;
    logic [15:0] w;
    logic [3:0]  g;
    logic        first2;

    assign w = PROG_DATA;
    assign g = w[15:12];
    // first word of one of the four double-word forms
    assign first2 = (g == `CID_GRP_MOVE) || (g == `CID_GRP_GOTO) ||
                    (g == `CID_GRP_CTL && w[11:8] == `CID_CTL_CALL) ||
                    (g == `CID_GRP_LIT && w[11:8] == `CID_LIT_PTR);

    always_comb begin
        next_s = s;
        next_s.exec = 1'b0;
        unique case (s.ph)
            PH_Q1: begin
                next_s.ph = PH_Q2;
            end
            PH_Q2: begin
                next_s.ph = PH_Q3;
                next_s.o = NOP_OUT;
                next_s.tw = 1'b0;
                next_s.chg = 1'b0;
                next_s.skp = 1'b0;
                if (s.md == MD_FLUSH) begin
                    next_s.o = NOP_OUT;
                end else if (s.md == MD_WORD2) begin
                    // complete double-word form from both words
                    next_s.o.nop = 1'b0;
                    next_s.o.opc = s.ir[15:10];
                    unique case (s.ir[15:12])
                        `CID_GRP_GOTO: begin
                            next_s.o.cls = CLS_CTL;
                            next_s.tgt = {w[11:0], s.ir[7:0]};
                            next_s.chg = 1'b1;
                        end
                        `CID_GRP_CTL: begin
                            next_s.o.cls = CLS_CTL;
                            next_s.tgt = {w[11:0], s.ir[7:0]};
                            next_s.chg = 1'b1;
                            next_s.o.push = 1'b1;
                            next_s.o.ssave = s.ir[`CID_S_POS];
                        end
                        `CID_GRP_MOVE: begin
                            next_s.o.cls = CLS_BYTE;
                            next_s.o.fadr = s.ir[11:0];
                            next_s.o.fdst = w[11:0];
                            next_s.o.wfile = 1'b1;
                        end
                        default: begin
                            next_s.o.cls = CLS_LIT;
                            next_s.o.psel = s.ir[5:4];
                            next_s.o.lit = {s.ir[3:0], w[7:0]};
                            next_s.o.pld = 1'b1;
                        end
                    endcase
                end else if (g == `CID_W2_TAG) begin
                    next_s.o = NOP_OUT;
                end else if (first2) begin
                    next_s.ir = w;
                    next_s.tw = 1'b1;
                end else begin
                    next_s.o.nop = 1'b0;
                    next_s.o.opc = w[15:10];
                    if (g <= `CID_BYTE_MAX) begin
                        next_s.o.cls = CLS_BYTE;
                        next_s.o.fadr = {4'h0, w[7:0]};
                        next_s.o.wfile = w[`CID_D_POS];
                        next_s.o.wacc = ~w[`CID_D_POS];
                        next_s.o.bank = w[`CID_A_POS];
                    end else if (g <= `CID_BIT_MAX) begin
                        next_s.o.cls = CLS_BIT;
                        next_s.o.fadr = {4'h0, w[7:0]};
                        next_s.o.bmask = 8'h01 << w[11:9];
                        next_s.o.bank = w[`CID_A_POS];
                        next_s.skp = (g == `CID_BIT_SKC) || (g == `CID_BIT_SKS);
                    end else if (g == `CID_GRP_LIT) begin
                        next_s.o.cls = CLS_LIT;
                        next_s.o.lit = {4'h0, w[7:0]};
                    end else if (g == `CID_GRP_EXT) begin
                        next_s.o.cls = CLS_CTL;
                        next_s.o.ext = 1'b1;
                        next_s.o.opc = {3'h0, w[11:9]};
                    end else begin
                        next_s.o.cls = CLS_CTL;
                        if (w[11:8] == `CID_CTL_RET) begin
                            next_s.tgt = RET_ADDR;
                            next_s.chg = 1'b1;
                            next_s.o.pop = 1'b1;
                            next_s.o.srest = w[`CID_S_POS];
                        end else if (w[11:8] == `CID_CTL_TBL) begin
                            next_s.o.tmode = w[1:0];
                            next_s.o.trd = ~w[`CID_TW_POS];
                            next_s.o.twr = w[`CID_TW_POS];
                        end else if (w[11:8] == `CID_CTL_BRA) begin
                            next_s.tgt = 20'(s.pc + 20'h00001 +
                                         {{12{w[7]}}, w[7:0]});
                            next_s.chg = 1'b1;
                        end
                    end
                end
            end
            PH_Q3: begin
                next_s.ph = PH_Q4;
                next_s.exec = 1'b1;
            end
            PH_Q4: begin
                next_s.ph = PH_Q1;
                next_s.adv = 1'b0;
                if (s.tw) begin
                    next_s.md = MD_WORD2;
                    next_s.pc = 20'(s.pc + 20'h00001);
                end else if (s.chg) begin
                    next_s.pc = s.tgt;
                    next_s.md = (s.md == MD_WORD2) ? MD_RUN : MD_FLUSH;
                end else if (s.skp && COND_TRUE) begin
                    next_s.pc = 20'(s.pc + 20'h00001);
                    next_s.md = MD_FLUSH;
                    next_s.adv = 1'b1;
                end else if (s.md == MD_FLUSH) begin
                    next_s.pc = 20'(s.pc + {19'h00000, s.adv});
                    next_s.md = MD_RUN;
                end else begin
                    next_s.pc = 20'(s.pc + 20'h00001);
                    next_s.md = MD_RUN;
                end
            end
        endcase
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            s <= RST_ST;
        end else begin
            s <= next_s;
        end
    end

    assign PROG_ADDR = s.pc;
    assign EXEC_STB = s.exec;
    assign IS_NOP = s.o.nop;
    assign OP_CLASS = s.o.cls;
    assign OPCODE = s.o.opc;
    assign FILE_ADDR = s.o.fadr;
    assign FILE_DST = s.o.fdst;
    assign WR_FILE = s.o.wfile;
    assign WR_ACCUM = s.o.wacc;
    assign BANKED = s.o.bank;
    assign BIT_MASK = s.o.bmask;
    assign LITERAL = s.o.lit;
    assign PTR_SEL = s.o.psel;
    assign PTR_LOAD = s.o.pld;
    assign SHADOW_SAVE = s.o.ssave;
    assign SHADOW_RESTORE = s.o.srest;
    assign TBL_MODE = s.o.tmode;
    assign TBL_RD = s.o.trd;
    assign TBL_WR = s.o.twr;
    assign EXT_OP = s.o.ext;
    assign STACK_PUSH = s.o.push;
    assign STACK_POP = s.o.pop;

    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!RST_N);

    sequence q_cycle;
        s.ph == PH_Q2 ##1 s.ph == PH_Q3 ##1 s.ph == PH_Q4 ##1 s.ph == PH_Q1;
    endsequence
    sequence q_flush_nop;
        s.md == MD_FLUSH ##3 (IS_NOP && EXEC_STB);
    endsequence

    a_phase_order: assert property (s.ph == PH_Q1 |=> q_cycle)
        else $error("phase sequence broken");
    a_exec_period: assert property (EXEC_STB |=> !EXEC_STB [*3] ##1 EXEC_STB)
        else $error("exec strobe not every four clocks");
    a_lone_second: assert property (s.ph == PH_Q2 && s.md == MD_RUN &&
        g == `CID_W2_TAG |=> IS_NOP && !STACK_PUSH && !TBL_WR && !PTR_LOAD)
        else $error("lone second word not a no-operation");
    a_two_word: assert property (s.ph == PH_Q2 && s.md == MD_RUN && first2
        |=> ##3 (s.md == MD_WORD2 && s.pc == $past(s.pc, 4) + 20'h00001)
        ##4 s.md == MD_RUN)
        else $error("double-word form not two cycles");
    a_single_pc: assert property (s.ph == PH_Q4 && s.md == MD_RUN && !s.tw &&
        !s.chg && !s.skp |=> s.md == MD_RUN && s.pc == $past(s.pc) + 20'h00001)
        else $error("single word did not advance by one");
    a_jump_flush: assert property (s.ph == PH_Q4 && s.md == MD_RUN && s.chg
        |=> s.pc == $past(s.tgt) ##0 q_flush_nop)
        else $error("jump without flush cycle");
    a_skip_flush: assert property (s.ph == PH_Q4 && s.md == MD_RUN && s.skp &&
        COND_TRUE |=> q_flush_nop)
        else $error("taken skip without flush cycle");
    a_dest_select: assert property (!IS_NOP && OP_CLASS == CLS_BYTE && FILE_DST == 12'h000
        |-> WR_FILE != WR_ACCUM)
        else $error("destination select not exclusive");
    a_bit_onehot: assert property (!IS_NOP && OP_CLASS == CLS_BIT |-> $onehot(BIT_MASK))
        else $error("bit select not a single bit");
    a_shadow_pair: assert property (SHADOW_SAVE |-> STACK_PUSH && !SHADOW_RESTORE)
        else $error("shadow save outside a call");
    a_table_dir: assert property (TBL_RD |-> !TBL_WR && OP_CLASS == CLS_CTL)
        else $error("table read and write together");
    a_nop_quiet: assert property (IS_NOP |-> !WR_FILE && !WR_ACCUM && !PTR_LOAD)
        else $error("no-operation with a write");
    a_nop_stack: assert property (IS_NOP |->
        !STACK_PUSH && !STACK_POP && !TBL_RD && !TBL_WR)
        else $error("no-operation touches stack or table");
    a_byte_fields: assert property (s.ph == PH_Q2 && s.md == MD_RUN &&
        g <= `CID_BYTE_MAX |=> OP_CLASS == CLS_BYTE && FILE_ADDR == {4'h0, $past(w[7:0])})
        else $error("byte operand fields wrong");
    a_dest_bit: assert property (s.ph == PH_Q2 && s.md == MD_RUN &&
        g <= `CID_BYTE_MAX |=> WR_FILE == $past(w[`CID_D_POS]) && WR_ACCUM != WR_FILE)
        else $error("destination select not taken from word");
    a_access_bit: assert property (s.ph == PH_Q2 && s.md == MD_RUN &&
        g <= `CID_BYTE_MAX |=> BANKED == $past(w[`CID_A_POS]))
        else $error("access select not taken from word");
    a_bit_select: assert property (s.ph == PH_Q2 && s.md == MD_RUN &&
        g > `CID_BYTE_MAX && g <= `CID_BIT_MAX |=> BIT_MASK == 8'h01 << $past(w[11:9]))
        else $error("bit select not the coded bit");
    a_move_pair: assert property (s.ph == PH_Q2 && s.md == MD_WORD2 &&
        s.ir[15:12] == `CID_GRP_MOVE |=> FILE_ADDR == $past(s.ir[11:0]) &&
        FILE_DST == $past(w[11:0]) && WR_FILE)
        else $error("move operands not joined from both words");
    a_word2_jump: assert property (s.ph == PH_Q4 && s.md == MD_WORD2 && s.chg
        |=> s.md == MD_RUN && s.pc == $past(s.tgt))
        else $error("double-word jump not direct");
    a_skip_untaken: assert property (s.ph == PH_Q4 && s.md == MD_RUN && s.skp &&
        !COND_TRUE |=> s.md == MD_RUN && s.pc == $past(s.pc) + 20'h00001)
        else $error("untaken skip did not advance by one");
    a_decode_holds: assert property (s.ph != PH_Q2 |=> $stable(s.o))
        else $error("decode outputs changed mid-cycle");
    a_addr_holds: assert property (s.ph != PH_Q4 |=> $stable(PROG_ADDR))
        else $error("fetch address changed mid-cycle");
    a_ext_group: assert property (EXT_OP |-> OP_CLASS == CLS_CTL && OPCODE[5:3] == 3'h0)
        else $error("extended op outside control group");
    a_shadow_rest: assert property (SHADOW_RESTORE |-> STACK_POP && !SHADOW_SAVE)
        else $error("shadow restore outside a return");
    a_table_wr: assert property (TBL_WR |-> !TBL_RD && OP_CLASS == CLS_CTL)
        else $error("table write outside control group");
    a_first_nop: assert property (s.ph == PH_Q2 && s.md == MD_RUN && first2 |=> IS_NOP)
        else $error("first word of double-word not idle");
endmodule
`default_nettype wire

// [cid_prog_mem.sv]
`default_nettype none
module cid_prog_mem (
    input  wire logic        clk,
    input  wire logic        slow,
    input  wire logic [19:0] addr,
    output logic      [15:0] data
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] rom [0:255];
    logic [19:0] last;
    initial begin
        for (int i = 0; i < 256; i++) begin
            rom[i] = 16'h0000;
        end
    end
    // fetch address history, one clock deep
    always_ff @(posedge clk) begin
        last <= addr;
    end
    // slow mode shows the inverted word for one clock after any change of address
    always_comb begin
        data = (slow && addr != last) ? ~rom[addr[7:0]] : rom[addr[7:0]];
    end
endmodule
`default_nettype wire

// [core_instruction_decoder_test.sv]
`default_nettype none
module core_instruction_decoder_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic        core_clk, rst_n, cond_true, slow, exec_stb, is_nop, wr_file, wr_accum;
    logic        banked, ptr_load, sh_save, sh_rest, tbl_rd, tbl_wr, ext_op, push, pop, gap_on;
    logic [19:0] prog_addr, ret_addr;
    logic [15:0] prog_data;
    logic [11:0] file_addr, file_dst, literal;
    logic [7:0]  bit_mask;
    logic [5:0]  opcode;
    logic [1:0]  op_class, ptr_sel, tbl_mode;
    int          n_errors, tests_run;

    cid_decoder dut (.CORE_CLK(core_clk), .RST_N(rst_n), .PROG_DATA(prog_data),
        .COND_TRUE(cond_true), .RET_ADDR(ret_addr), .PROG_ADDR(prog_addr),
        .EXEC_STB(exec_stb), .IS_NOP(is_nop), .OP_CLASS(op_class), .OPCODE(opcode),
        .FILE_ADDR(file_addr), .FILE_DST(file_dst), .WR_FILE(wr_file), .WR_ACCUM(wr_accum),
        .BANKED(banked), .BIT_MASK(bit_mask), .LITERAL(literal), .PTR_SEL(ptr_sel),
        .PTR_LOAD(ptr_load), .SHADOW_SAVE(sh_save), .SHADOW_RESTORE(sh_rest),
        .TBL_MODE(tbl_mode), .TBL_RD(tbl_rd), .TBL_WR(tbl_wr), .EXT_OP(ext_op),
        .STACK_PUSH(push), .STACK_POP(pop));
    cid_prog_mem mem (.clk(core_clk), .slow(slow), .addr(prog_addr), .data(prog_data));

    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    task automatic summarize();
        $display("errors %0d checks %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // wait for the next execute strobe, then check address and nop flag
    task automatic step(input logic [19:0] a, input logic n);
        int cnt;
        cnt = 0;
        do begin
            @(negedge core_clk);
            cnt++;
        end while (exec_stb !== 1'b1 && cnt < 20);
        if (cnt >= 20) begin
            n_errors++;
            $display("Error at %0t: no execute strobe", $time);
            summarize();
        end else begin
            if (gap_on) check(cnt, 4, "cycle length");
            gap_on = 1'b1;
            check(prog_addr, a, "fetch address");
            check(is_nop, n, "nop flag");
        end
    endtask

    task automatic t_reset();
        rst_n = 1'b0;
        repeat (3) @(negedge core_clk);
        check({exec_stb, is_nop}, 2'b01, "reset outputs");
        check(prog_addr, 0, "reset address");
        rst_n = 1'b1;
        gap_on = 1'b0;
        step(20'h0, 1'b0);
        check(file_addr[7:0], 8'h5a, "first word");
        $display("test reset done");
    endtask

    task automatic t_byte();
        check(op_class, 0, "byte class");
        check(opcode, 6'h0c, "opcode");
        check({wr_file, wr_accum, banked}, 3'b100, "dest access");
        step(20'h1, 1'b0);
        check({wr_file, wr_accum, banked}, 3'b011, "dest access");
        check(file_addr[7:0], 8'ha5, "file");
        $display("test byte done");
    endtask

    task automatic t_bit_skip();
        step(20'h2, 1'b0);
        check({op_class, bit_mask, banked}, {2'h1, 8'h20, 1'b1}, "bit op");
        cond_true = 1'b1;
        step(20'h3, 1'b0);
        check(bit_mask, 8'h01, "skip mask");
        step(20'h4, 1'b1);
        cond_true = 1'b0;
        step(20'h5, 1'b0);
        step(20'h6, 1'b0);
        $display("test skip done");
    endtask

    task automatic t_double();
        check({op_class, literal[7:0], ptr_load}, {2'h2, 8'h7c, 1'b0}, "literal");
        step(20'h7, 1'b1);
        step(20'h8, 1'b0);
        check({ptr_load, ptr_sel, literal}, {1'b1, 2'h2, 12'hcab}, "ptr load");
        step(20'h9, 1'b1);
        step(20'ha, 1'b0);
        check({file_addr, file_dst}, 24'h123456, "move");
        step(20'hb, 1'b1);
        check({wr_file, wr_accum, push, pop, ptr_load}, 5'h0, "lone word");
        $display("test double done");
    endtask

    task automatic t_table();
        for (int i = 0; i < 4; i++) begin
            step(20'hc + 20'(i), 1'b0);
            check({op_class, tbl_mode, tbl_rd, tbl_wr}, {2'h3, 2'(i), 2'b10}, "tbl rd");
        end
        step(20'h10, 1'b0);
        check({tbl_mode, tbl_rd, tbl_wr}, 4'b1101, "tbl wr");
        step(20'h11, 1'b0);
        check({ext_op, opcode}, {1'b1, 6'h05}, "extended");
        $display("test table done");
    endtask

    task automatic t_flow();
        slow = 1'b1;
        step(20'h12, 1'b0);
        step(20'h23, 1'b1);
        step(20'h23, 1'b0);
        check(file_addr[7:0], 8'hc3, "branch target");
        step(20'h24, 1'b1);
        step(20'h25, 1'b0);
        check({push, sh_save}, 2'b11, "fast call");
        step(20'h41, 1'b0);
        check({pop, sh_rest, sh_save}, 3'b110, "fast return");
        step(20'h50, 1'b1);
        step(20'h50, 1'b1);
        step(20'h51, 1'b0);
        step(20'h90, 1'b0);
        check(file_addr[7:0], 8'h99, "goto target");
        $display("test flow done");
    endtask

    initial begin
        rst_n = 1'b0;
        cond_true = 1'b0;
        slow = 1'b0;
        ret_addr = 20'h00050;
        n_errors = 0;
        tests_run = 0;
        gap_on = 1'b0;
        @(negedge core_clk);
        mem.rom[0] = 16'h325a;
        mem.rom[1] = 16'h21a5;
        mem.rom[2] = 16'h7b33;
        mem.rom[3] = 16'h9010;
        mem.rom[4] = 16'h3fff;
        mem.rom[5] = 16'h8000;
        mem.rom[6] = 16'ha07c;
        mem.rom[7] = 16'haf2c;
        mem.rom[8] = 16'hf0ab;
        mem.rom[9] = 16'hc123;
        mem.rom[10] = 16'hf456;
        mem.rom[11] = 16'hf777;
        for (int i = 0; i < 4; i++) begin
            mem.rom[12 + i] = 16'hb300 + 16'(i);
        end
        mem.rom[16] = 16'hb307;
        mem.rom[17] = 16'hea00;
        mem.rom[18] = 16'hb410;
        mem.rom[35] = 16'h30c3;
        mem.rom[36] = 16'hb241;
        mem.rom[37] = 16'hf000;
        mem.rom[65] = 16'hb101;
        mem.rom[80] = 16'hd090;
        mem.rom[81] = 16'hf000;
        mem.rom[144] = 16'h3099;
        t_reset();
        t_byte();
        t_bit_skip();
        t_double();
        t_table();
        t_flow();
        t_reset();
        summarize();
    end
endmodule
`default_nettype wire
